/* rtl/ulpi_phy_carkit_charger_regs.sv */
// carkit event latch, hs_signal_compensation and charger-detection registers
`timescale 1ns/1ps
`default_nettype none

module ulpi_phy_carkit_charger_regs
  import carkit_charger_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // immediate register access from the ulpi command decoder
  input wire logic [5:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic vendor_hit_out,
  // interrupt enables and converter status from neighbouring registers
  input wire logic id_open_rise_en_in,
  input wire logic id_open_fall_en_in,
  input wire logic data_detect_irq_en_in,
  input wire logic resistor_measure_irq_en_in,
  input wire logic resistor_measure_done_in,
  // analog front end sense
  input wire logic id_floating_in,
  input wire logic dp_voltage_in,
  input wire logic dm_voltage_in,
  input wire logic [1:0] line_state_in,
  // analog front end controls and the registered data-detect status
  output logic [1:0] squelch_threshold_sel_out,
  output logic [2:0] tx_amplitude_boost_out,
  output logic vsrc_dp_out,
  output logic vsrc_dm_out,
  output logic isink_dp_out,
  output logic isink_dm_out,
  output logic contact_dp_out,
  output logic contact_dm_out,
  output logic data_detect_status_out,
  // alt_int request towards the rxcmd builder
  output logic alt_int_out
);

  logic id_open_event;
  logic data_detect_event;
  logic resistor_measure_event;
  logic id_floating_q;
  logic done_q;
  logic status_q;
  logic data_voltage_source_en;
  logic data_current_sink_en;
  logic contact_current_source_en;
  logic charging_host_port_sel;
  logic next_status;
  logic set_id;
  logic set_data;
  logic set_res;
  logic latch_read;
  logic vendor_addr;
  logic [7:0] next_rdata;

  // vendor window decode; addresses arrive only from immediate commands
  assign vendor_addr = (reg_addr_in >= ADDR_VENDOR_LO) && (reg_addr_in <= ADDR_VENDOR_HI);
  assign vendor_hit_out = vendor_addr;
  assign latch_read = reg_rd_in && (reg_addr_in == ADDR_EVENT_LATCH);

  // comparator sees dm instead of dp in host mode, gated by sink enable and se0
  assign next_status = data_current_sink_en
    && (charging_host_port_sel ? dm_voltage_in : dp_voltage_in)
    && (line_state_in == LINE_STATE_SE0);

  // event detection on sampled previous values
  assign set_id = (id_floating_in && !id_floating_q && id_open_rise_en_in)
    || (!id_floating_in && id_floating_q && id_open_fall_en_in);
  assign set_data = (next_status != status_q) && data_detect_irq_en_in;
  assign set_res = resistor_measure_done_in && !done_q && resistor_measure_irq_en_in;

  // history of the sensed levels used for edge detection
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      id_floating_q <= 1'b0;
      done_q <= 1'b0;
      status_q <= 1'b0;
    end
    else
    begin
      id_floating_q <= id_floating_in;
      done_q <= resistor_measure_done_in;
      status_q <= next_status;
    end
  end

  // sticky latches; a set in the read cycle beats the read clear
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      id_open_event <= 1'b0;
      data_detect_event <= 1'b0;
      resistor_measure_event <= 1'b0;
    end
    else
    begin
      id_open_event <= set_id || (id_open_event && !latch_read);
      data_detect_event <= set_data || (data_detect_event && !latch_read);
      resistor_measure_event <= set_res || (resistor_measure_event && !latch_read);
    end
  end

  // compensation register; only the documented fields hold state
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      squelch_threshold_sel_out <= SQUELCH_RESET;
      tx_amplitude_boost_out <= BOOST_RESET;
    end
    else if (reg_wr_in && reg_addr_in == ADDR_COMPENSATION)
    begin
      squelch_threshold_sel_out <= reg_wdata_in[SQUELCH_MSB:SQUELCH_LSB];
      tx_amplitude_boost_out <= reg_wdata_in[BOOST_MSB:BOOST_LSB];
    end
  end

  // charger-detection controls; status and reserved bits are not writable
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      {charging_host_port_sel, contact_current_source_en, data_current_sink_en,
        data_voltage_source_en} <= CHG_CTRL_RESET;
    end
    else if (reg_wr_in && reg_addr_in == ADDR_CHARGER_DET)
    begin
      data_voltage_source_en <= reg_wdata_in[CHG_VSRC];
      data_current_sink_en <= reg_wdata_in[CHG_ISINK];
      contact_current_source_en <= reg_wdata_in[CHG_CONTACT];
      charging_host_port_sel <= reg_wdata_in[CHG_HOST];
    end
  end

  // analog steering; host mode moves every function to the other data line
  assign vsrc_dp_out = data_voltage_source_en && !charging_host_port_sel;
  assign vsrc_dm_out = data_voltage_source_en && charging_host_port_sel;
  assign isink_dp_out = data_current_sink_en && !charging_host_port_sel;
  assign isink_dm_out = data_current_sink_en && charging_host_port_sel;
  assign contact_dp_out = contact_current_source_en && !charging_host_port_sel;
  assign contact_dm_out = contact_current_source_en && charging_host_port_sel;
  assign data_detect_status_out = status_q;

  // a new latch set is raised to the link as alt_int for one cycle
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      alt_int_out <= 1'b0;
    else
      alt_int_out <= set_id || set_data || set_res;
  end

  // read mux; unmapped addresses and reserved bits return zero
  always_comb
  begin
    next_rdata = READ_ZERO;
    case (reg_addr_in)
      ADDR_EVENT_LATCH:
      begin
        next_rdata[LATCH_ID_OPEN] = id_open_event;
        next_rdata[LATCH_DATA_DETECT] = data_detect_event;
        next_rdata[LATCH_CAR_DPLUS] = 1'b0;
        next_rdata[LATCH_RESISTOR] = resistor_measure_event;
      end
      ADDR_COMPENSATION:
      begin
        next_rdata[SQUELCH_MSB:SQUELCH_LSB] = squelch_threshold_sel_out;
        next_rdata[BOOST_MSB:BOOST_LSB] = tx_amplitude_boost_out;
      end
      ADDR_CHARGER_DET:
      begin
        next_rdata[CHG_VSRC] = data_voltage_source_en;
        next_rdata[CHG_ISINK] = data_current_sink_en;
        next_rdata[CHG_CONTACT] = contact_current_source_en;
        next_rdata[CHG_HOST] = charging_host_port_sel;
        next_rdata[CHG_STATUS] = status_q;
      end
      default:
        next_rdata = READ_ZERO;
    endcase
  end

  // read data is captured on the read strobe and held until the next read
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      reg_rdata_out <= READ_ZERO;
    else if (reg_rd_in)
      reg_rdata_out <= next_rdata;
  end

  // assertions
  AST_ID_RISE: assert property (@(posedge clk_in) disable iff (rst_in)
    id_open_rise_en_in && id_floating_in && !$past(id_floating_in) |=> id_open_event)
    else $error("id open rise not latched");
  AST_DATA_EVT: assert property (@(posedge clk_in) disable iff (rst_in)
    $past(data_detect_irq_en_in) && $changed(status_q) |-> data_detect_event)
    else $error("data detect change not latched");
  AST_RES_EVT: assert property (@(posedge clk_in) disable iff (rst_in)
    resistor_measure_irq_en_in && $rose(resistor_measure_done_in) |=> resistor_measure_event)
    else $error("conversion done not latched");
  AST_LATCH_ZERO: assert property (@(posedge clk_in) disable iff (rst_in)
    reg_rd_in && reg_addr_in == ADDR_EVENT_LATCH |=> reg_rdata_out[7:4] == 4'h0
      && !reg_rdata_out[LATCH_CAR_DPLUS])
    else $error("reserved latch bits not zero");
  AST_READ_CLEAR: assert property (@(posedge clk_in) disable iff (rst_in)
    latch_read && !set_id |=> !id_open_event)
    else $error("latch not cleared by read");
  AST_SET_WINS: assert property (@(posedge clk_in) disable iff (rst_in)
    latch_read && set_id |=> id_open_event ##1 (id_open_event || $past(latch_read)))
    else $error("event lost to read clear");
  AST_SINK_OFF: assert property (@(posedge clk_in) disable iff (rst_in)
    !data_current_sink_en |=> !data_detect_status_out)
    else $error("comparator active without sink");
  AST_LINE_STATE: assert property (@(posedge clk_in) disable iff (rst_in)
    line_state_in != LINE_STATE_SE0 |=> !data_detect_status_out)
    else $error("detect with non-se0 line state");
  AST_HOST_SWAP: assert property (@(posedge clk_in) disable iff (rst_in)
    charging_host_port_sel |-> !vsrc_dp_out && !isink_dp_out && !contact_dp_out)
    else $error("dp driven in host mode");
  AST_BOOST_WR: assert property (@(posedge clk_in) disable iff (rst_in)
    reg_wr_in && reg_addr_in == ADDR_COMPENSATION |=>
      tx_amplitude_boost_out == $past(reg_wdata_in[BOOST_MSB:BOOST_LSB])
      && squelch_threshold_sel_out == $past(reg_wdata_in[SQUELCH_MSB:SQUELCH_LSB]))
    else $error("compensation write not applied");
  AST_ALT_INT: assert property (@(posedge clk_in) disable iff (rst_in)
    set_id || set_data || set_res |=> alt_int_out)
    else $error("alt_int not raised");
  AST_RSV_READ: assert property (@(posedge clk_in) disable iff (rst_in)
    reg_rd_in && reg_addr_in == ADDR_COMPENSATION |=> reg_rdata_out[3:2] == 2'h0
      && !reg_rdata_out[7])
    else $error("reserved compensation bits not zero");

endmodule : ulpi_phy_carkit_charger_regs

`default_nettype wire

/* rtl/carkit_charger_pkg.sv */
// constants for the carkit latch, compensation and charger-detection registers
package carkit_charger_pkg;
  // register addresses in the ulpi register space
  localparam logic [5:0] ADDR_EVENT_LATCH = 6'h21;
  localparam logic [5:0] ADDR_COMPENSATION = 6'h31;
  localparam logic [5:0] ADDR_CHARGER_DET = 6'h32;
  localparam logic [5:0] ADDR_VENDOR_LO = 6'h30;
  localparam logic [5:0] ADDR_VENDOR_HI = 6'h3F;
  // latch register fields
  localparam int LATCH_ID_OPEN = 0;
  localparam int LATCH_DATA_DETECT = 1;
  localparam int LATCH_CAR_DPLUS = 2;
  localparam int LATCH_RESISTOR = 3;
  // compensation register fields
  localparam int SQUELCH_LSB = 0;
  localparam int SQUELCH_MSB = 1;
  localparam int BOOST_LSB = 4;
  localparam int BOOST_MSB = 6;
  // charger-detection register fields
  localparam int CHG_VSRC = 0;
  localparam int CHG_ISINK = 1;
  localparam int CHG_CONTACT = 2;
  localparam int CHG_HOST = 3;
  localparam int CHG_STATUS = 4;
  // reset values and the idle line state that gates data detection
  localparam logic [1:0] SQUELCH_RESET = 2'h0;
  localparam logic [2:0] BOOST_RESET = 3'h0;
  localparam logic [3:0] CHG_CTRL_RESET = 4'h0;
  localparam logic [1:0] LINE_STATE_SE0 = 2'h0;
  localparam logic [7:0] READ_ZERO = 8'h00;
endpackage : carkit_charger_pkg

/* sim/ulpi_link_model.sv */
// link controller model issuing immediate register reads and writes
`timescale 1ns/1ps
`default_nettype none
module ulpi_link_model (
  // clock
  input wire logic clk_in,
  // register access towards the phy
  output logic [5:0] reg_addr_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_wdata_out,
  input wire logic [7:0] reg_rdata_in
);
  // idle bus at time zero
  initial
  begin
    reg_addr_out = 6'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_wdata_out = 8'h00;
  end
  // one strobe cycle; address and data are scrambled after release
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_in);
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(negedge clk_in);
    reg_wr_out = 1'b0;
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
  endtask : wr_reg
  // read data is taken one cycle after the strobe edge
  task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk_in);
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(negedge clk_in);
    reg_rd_out = 1'b0;
    reg_addr_out = ~a;
    d = reg_rdata_in;
  endtask : rd_reg
endmodule : ulpi_link_model
`default_nettype wire

/* sim/test_ulpi_phy_carkit_charger_regs.sv */
// self-checking bench for the carkit latch, compensation and charger registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t %h %h", $time, (a), (b)); end end
module test_ulpi_phy_carkit_charger_regs;
  import carkit_charger_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [5:0] addr;
  logic wr, rd, hit, alt, st;
  logic [7:0] wdata, rdata, r, d;
  logic rise_en = 1'b0, fall_en = 1'b0, dd_en = 1'b0, rid_en = 1'b0, rid_done = 1'b0;
  logic id_fl = 1'b0, dp = 1'b0, dm = 1'b0;
  logic [1:0] ls = 2'h0;
  logic [1:0] sq;
  logic [2:0] bst;
  wire logic [5:0] steer;
  logic [31:0] seed = 32'h0000BB8B;
  logic [31:0] w;
  logic [5:0] rst_q[$] = '{ADDR_EVENT_LATCH, ADDR_COMPENSATION, ADDR_CHARGER_DET};
  int errors = 0, tests_run = 0, i, cm, chm, lm;
  // free-running bench clock
  always #2 clk_in = ~clk_in;
  ulpi_link_model link (.clk_in(clk_in), .reg_addr_out(addr), .reg_wr_out(wr),
    .reg_rd_out(rd), .reg_wdata_out(wdata), .reg_rdata_in(rdata));
  ulpi_phy_carkit_charger_regs dut (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .vendor_hit_out(hit), .id_open_rise_en_in(rise_en), .id_open_fall_en_in(fall_en),
    .data_detect_irq_en_in(dd_en), .resistor_measure_irq_en_in(rid_en),
    .resistor_measure_done_in(rid_done), .id_floating_in(id_fl), .dp_voltage_in(dp),
    .dm_voltage_in(dm), .line_state_in(ls), .squelch_threshold_sel_out(sq),
    .tx_amplitude_boost_out(bst), .vsrc_dp_out(steer[5]), .vsrc_dm_out(steer[4]),
    .isink_dp_out(steer[3]), .isink_dm_out(steer[2]), .contact_dp_out(steer[1]),
    .contact_dm_out(steer[0]), .data_detect_status_out(st), .alt_int_out(alt));
  // xorshift source for register data and sense inputs
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // an event seen at one edge gives exactly one alt_int cycle
  task automatic alt_pulse();
    @(negedge clk_in);
    `CHK(alt, 1'b1)
    @(negedge clk_in);
    `CHK(alt, 1'b0)
  endtask : alt_pulse
  // latch read returns the model's bits, then the model clears too
  task automatic rd_latch();
    link.rd_reg(ADDR_EVENT_LATCH, r);
    `CHK(r, lm[7:0])
    lm = 0;
  endtask : rd_latch
  task automatic print_verdict();
    if (errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict
  // watchdog: the sequence needs well under a thousand cycles
  initial
  begin
    #(10000 * 4);
    errors++;
    print_verdict();
  end
  // main sequence
  initial
  begin
    lm = 0;
    repeat (16) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'b0;
    foreach (rst_q[k])
    begin
      link.rd_reg(rst_q[k], r);
      `CHK(r, READ_ZERO)
    end
    // compensation fields; latch writes must not stick
    for (i = 0; i < 8; i++)
    begin
      d = 8'(xs());
      link.wr_reg(ADDR_COMPENSATION, d);
      link.wr_reg(ADDR_EVENT_LATCH, d);
      cm = d & 8'h73;
      `CHK({1'b0, bst, 2'h0, sq}, cm[7:0])
      link.rd_reg(ADDR_COMPENSATION, r);
      `CHK(r, cm[7:0])
      rd_latch();
    end
    // charger control with random sense; interrupt enables are off
    for (i = 0; i < 16; i++)
    begin
      w = xs();
      {id_fl, ls, dm, dp, d} = w[12:0];
      link.wr_reg(ADDR_CHARGER_DET, d);
      @(negedge clk_in);
      chm = {d[1] & (d[3] ? dm : dp) & (ls == LINE_STATE_SE0), d[3:0]};
      `CHK(st, chm[4])
      `CHK(steer, {d[0], d[0], d[1], d[1], d[2], d[2]} & {3{~d[3], d[3]}})
      link.rd_reg(ADDR_CHARGER_DET, r);
      `CHK(r, chm[7:0])
    end
    rd_latch();
    // sweep the whole address space: decode flag and read data
    for (i = 0; i < 64; i++)
    begin
      fork
        link.rd_reg(6'(i), r);
        begin
          @(negedge clk_in);
          #1;
          `CHK(hit, i >= 48)
        end
      join
      `CHK(r, 8'(i == 'h31 ? cm : i == 'h32 ? chm : 0))
    end
    // id float rise then fall, each with only its own edge enabled
    link.wr_reg(ADDR_CHARGER_DET, 8'h00);
    id_fl = 1'b0;
    rise_en = 1'b1;
    repeat (2) @(negedge clk_in);
    id_fl = 1'b1;
    alt_pulse();
    rise_en = 1'b0;
    fall_en = 1'b1;
    id_fl = 1'b0;
    alt_pulse();
    lm = 1;
    rd_latch();
    rd_latch();
    // conversion done: ignored while disabled, latched on rise when enabled
    rid_done = 1'b1;
    @(negedge clk_in);
    `CHK(alt, 1'b0)
    rid_done = 1'b0;
    rid_en = 1'b1;
    @(negedge clk_in);
    rid_done = 1'b1;
    alt_pulse();
    lm = 8;
    rd_latch();
    // comparator change with its enable set first; enabling the sink causes the change
    dd_en = 1'b1;
    dp = 1'b1;
    ls = LINE_STATE_SE0;
    link.wr_reg(ADDR_CHARGER_DET, 8'h02);
    repeat (3) @(negedge clk_in);
    lm = 2;
    rd_latch();
    // event at the same edge as a latch read survives the clear
    rise_en = 1'b1;
    fork
      link.rd_reg(ADDR_EVENT_LATCH, r);
      begin
        @(negedge clk_in);
        id_fl = 1'b1;
      end
    join
    `CHK(r, READ_ZERO)
    lm = 1;
    rd_latch();
    // charger enables back off before normal operation
    link.wr_reg(ADDR_CHARGER_DET, 8'h00);
    @(negedge clk_in);
    `CHK({steer, st}, 7'h00)
    print_verdict();
  end
endmodule : test_ulpi_phy_carkit_charger_regs
`default_nettype wire
